/* File: src/pss_sequencer.sv */
// Parameter set sequencer: controlled advance and line addressed pick
`default_nettype none
`include "pss_consts.svh"

module pss_sequencer (
  // Clock and reset
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_I,
  // Configuration
  input  wire logic                    SEQUENCER_ON_I,
  input  wire logic                    SET_STEPPING_STYLE_I,
  input  wire logic [`PSS_CNT_W-1:0]   SET_COUNT_I,
  input  wire logic                    LINE_INVERT_I,
  input  wire logic                    SOURCE_TARGET_SELECT_I,
  input  wire logic [1:0]              SOURCE_CHOICE_I,
  input  wire logic                    SOURCE_WRITE_I,
  input  wire logic [`PSS_IDX_W-1:0]   SET_POINTER_I,
  // Commands
  input  wire logic                    SAVE_ACTIVE_TO_SLOT_I,
  input  wire logic                    COPY_SLOT_TO_ACTIVE_I,
  input  wire logic                    UNSYNCED_STEP_CMD_I,
  input  wire logic                    UNSYNCED_REWIND_CMD_I,
  input  wire logic                    ACTIVE_WR_I,
  input  wire logic [`PSS_PARAM_W-1:0] ACTIVE_WDATA_I,
  // Pins and acquisition
  input  wire logic                    INPUT_LINE_ONE_I,
  input  wire logic                    FRAME_TRIGGER_I,
  input  wire logic                    FRAME_DONE_I,
  // Status
  output logic [`PSS_PARAM_W-1:0]      ACTIVE_PARAM_O,
  output logic                         WAITING_FOR_TRIGGER_O,
  output logic                         FRAME_START_O,
  output logic [`PSS_IDX_W-1:0]        CURRENT_SET_O,
  output logic                         SEQ_RUNNING_O
);
  pss_pkg::pss_state_t     state_reg;
  pss_pkg::pss_src_t       adv_src_reg;
  pss_pkg::pss_src_t       rst_src_reg;
  logic [2:0]              line_sync_reg;
  logic [2:0]              trig_sync_reg;
  logic                    line_reg;
  logic                    line_d_reg;
  logic                    trig_reg;
  logic                    trig_d_reg;
  logic                    on_d_reg;
  logic                    run_reg;
  logic                    start_pend_reg;
  logic                    fresh_reg;
  logic                    waiting_reg;
  logic                    frame_pulse_reg;
  logic                    ld_frm_reg;
  logic [`PSS_IDX_W-1:0]   ld_idx_reg;
  logic [`PSS_IDX_W-1:0]   cur_reg;
  logic [`PSS_PARAM_W-1:0] active_reg;
  logic [`PSS_PARAM_W-1:0] saved_reg;
  logic [63:0]             valid_reg;
  logic [`PSS_DLY_W-1:0]   settle_reg;
  logic [`PSS_DLY_W-1:0]   dly_reg [2];
  logic [1:0]              pend_reg;
  logic                    free;
  logic                    line_rise;
  logic                    line_chg;
  logic                    trig_ok;
  logic [`PSS_CNT_W-1:0]   cnt_cap;
  logic [`PSS_CNT_W-1:0]   cnt_lim;
  logic [`PSS_IDX_W-1:0]   last_idx;
  logic [`PSS_IDX_W-1:0]   sel_addr;
  logic                    restore_go;
  logic                    load_go;
  logic                    frame_go;
  logic [`PSS_IDX_W-1:0]   load_idx;
  logic                    load_frm;
  logic                    start_clr;
  logic [1:0]              clr;
  logic [1:0]              cmd_ok;
  logic [1:0]              set_ev;

  pss_mem_if u_mif ();

  pss_set_mem u_mem (
    .clk_i (CORE_CLK_I),
    .m     (u_mif.mem)
  );

  // Three stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      line_sync_reg <= 3'h0;
      trig_sync_reg <= 3'h0;
      line_reg      <= 1'b0;
      trig_reg      <= 1'b0;
      line_d_reg    <= 1'b0;
      trig_d_reg    <= 1'b0;
    end else begin
      line_sync_reg <= {line_sync_reg[1:0], INPUT_LINE_ONE_I};
      trig_sync_reg <= {trig_sync_reg[1:0], FRAME_TRIGGER_I};
      if (line_sync_reg[1] == line_sync_reg[2]) begin
        line_reg <= line_sync_reg[2];
      end
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_reg <= trig_sync_reg[2];
      end
      line_d_reg <= line_reg;
      trig_d_reg <= trig_reg;
    end
  end

  // Source selection registers
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      adv_src_reg <= pss_pkg::SRC_OFF;
      rst_src_reg <= pss_pkg::SRC_OFF;
    end else if (SOURCE_WRITE_I) begin
      if (SOURCE_TARGET_SELECT_I == `PSS_TGT_ADVANCE) begin
        unique case (SOURCE_CHOICE_I)
          `PSS_SRC_EVERY: adv_src_reg <= pss_pkg::SRC_EVERY;
          `PSS_SRC_LINE:  adv_src_reg <= pss_pkg::SRC_LINE;
          default:        adv_src_reg <= pss_pkg::SRC_OFF;
        endcase
      end else begin
        rst_src_reg <= (SOURCE_CHOICE_I == `PSS_SRC_LINE) ? pss_pkg::SRC_LINE : pss_pkg::SRC_OFF;
      end
    end
  end

  // Count limit per mode and the decision taken in the waiting state
  always_comb begin
    free       = (SET_STEPPING_STYLE_I == `PSS_STYLE_FREE);
    line_rise  = line_reg & ~line_d_reg;
    line_chg   = line_reg ^ line_d_reg;
    trig_ok    = trig_reg & ~trig_d_reg & waiting_reg;
    cnt_cap    = free ? `PSS_MAX_SETS_FREE : `PSS_MAX_SETS_CTRL;
    cnt_lim    = (SET_COUNT_I > cnt_cap) ? cnt_cap : SET_COUNT_I;
    if (cnt_lim == `PSS_CNT_ZERO) begin
      cnt_lim = `PSS_CNT_ONE;
    end
    last_idx   = `PSS_IDX_W'(cnt_lim - `PSS_CNT_ONE);
    sel_addr   = {5'h00, line_reg ^ LINE_INVERT_I};
    restore_go = 1'b0;
    load_go    = 1'b0;
    frame_go   = 1'b0;
    load_idx   = cur_reg;
    load_frm   = 1'b0;
    start_clr  = 1'b0;
    clr        = 2'b00;
    if (state_reg == pss_pkg::ST_WAIT) begin
      if (run_reg && !SEQUENCER_ON_I) begin
        restore_go = 1'b1;
      end else if (run_reg && start_pend_reg && !free) begin
        load_go   = 1'b1;
        load_idx  = `PSS_IDX_ZERO;
        start_clr = 1'b1;
      end else if (trig_ok) begin
        if (run_reg && free && (fresh_reg || sel_addr != cur_reg)) begin
          load_go  = 1'b1;
          load_idx = sel_addr;
          load_frm = 1'b1;
        end else begin
          frame_go = 1'b1;
        end
      end else if (run_reg && !free && pend_reg[1]) begin
        load_go  = 1'b1;
        load_idx = `PSS_IDX_ZERO;
        clr      = 2'b11;
      end else if (run_reg && !free && pend_reg[0]) begin
        load_go  = 1'b1;
        load_idx = (cur_reg >= last_idx) ? `PSS_IDX_ZERO : cur_reg + `PSS_IDX_ONE;
        clr      = 2'b01;
      end else if (COPY_SLOT_TO_ACTIVE_I) begin
        load_go  = 1'b1;
        load_idx = SET_POINTER_I;
      end
    end
  end

  // Memory strobes
  assign u_mif.we    = SAVE_ACTIVE_TO_SLOT_I;
  assign u_mif.waddr = SET_POINTER_I;
  assign u_mif.wdata = active_reg;
  assign u_mif.re    = (state_reg == pss_pkg::ST_FETCH);
  assign u_mif.raddr = ld_idx_reg;

  // Sequencing state machine and load bookkeeping
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_reg  <= pss_pkg::ST_WAIT;
      ld_idx_reg <= `PSS_IDX_ZERO;
      ld_frm_reg <= 1'b0;
      cur_reg    <= `PSS_IDX_ZERO;
    end else begin
      unique case (state_reg)
        pss_pkg::ST_WAIT: begin
          if (load_go) begin
            state_reg  <= pss_pkg::ST_FETCH;
            ld_idx_reg <= load_idx;
            ld_frm_reg <= load_frm;
          end else if (frame_go) begin
            state_reg <= pss_pkg::ST_FRAME;
          end
        end
        pss_pkg::ST_FETCH: state_reg <= pss_pkg::ST_APPLY;
        pss_pkg::ST_APPLY: begin
          cur_reg   <= ld_idx_reg;
          state_reg <= ld_frm_reg ? pss_pkg::ST_FRAME : pss_pkg::ST_WAIT;
        end
        pss_pkg::ST_FRAME: begin
          if (FRAME_DONE_I) begin
            state_reg <= pss_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  // Active parameters, pre-enable copy and slot validity
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      active_reg <= `PSS_RESET_PARAM;
      saved_reg  <= `PSS_RESET_PARAM;
      valid_reg  <= 64'h0000000000000000;
    end else begin
      if (SAVE_ACTIVE_TO_SLOT_I) begin
        valid_reg[SET_POINTER_I] <= 1'b1;
      end
      if (SEQUENCER_ON_I && !on_d_reg) begin
        saved_reg <= active_reg;
      end
      if (restore_go) begin
        active_reg <= saved_reg;
      end else if (state_reg == pss_pkg::ST_APPLY) begin
        active_reg <= valid_reg[ld_idx_reg] ? u_mif.rdata : `PSS_DEFAULT_PARAM;
      end else if (ACTIVE_WR_I && !run_reg) begin
        active_reg <= ACTIVE_WDATA_I;
      end
    end
  end

  // Enable tracking
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      on_d_reg       <= 1'b0;
      run_reg        <= 1'b0;
      start_pend_reg <= 1'b0;
      fresh_reg      <= 1'b0;
    end else begin
      on_d_reg <= SEQUENCER_ON_I;
      if (SEQUENCER_ON_I && !on_d_reg) begin
        run_reg        <= 1'b1;
        start_pend_reg <= 1'b1;
        fresh_reg      <= 1'b1;
      end else begin
        if (restore_go) begin
          run_reg <= 1'b0;
        end
        if (start_clr) begin
          start_pend_reg <= 1'b0;
        end
        if (state_reg == pss_pkg::ST_APPLY) begin
          fresh_reg <= 1'b0;
        end
      end
    end
  end

  // Line settling window in line addressed pick
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      settle_reg <= `PSS_DLY_ZERO;
    end else if (line_chg && free && run_reg) begin
      settle_reg <= `PSS_DLY_W'(`PSS_SETTLE_CYC);
    end else if (settle_reg != `PSS_DLY_ZERO) begin
      settle_reg <= settle_reg - `PSS_DLY_ONE;
    end
  end

  // Waiting status and frame start pulse
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      waiting_reg     <= 1'b0;
      frame_pulse_reg <= 1'b0;
    end else begin
      waiting_reg <= (state_reg == pss_pkg::ST_WAIT) && !load_go && !frame_go && !restore_go
                     && (settle_reg == `PSS_DLY_ZERO) && !(line_chg && free && run_reg);
      frame_pulse_reg <= frame_go || (state_reg == pss_pkg::ST_APPLY && ld_frm_reg);
    end
  end

  // Step and rewind sources feed delayed or direct pending flags
  assign cmd_ok[0] = UNSYNCED_STEP_CMD_I && adv_src_reg == pss_pkg::SRC_OFF;
  assign cmd_ok[1] = UNSYNCED_REWIND_CMD_I;
  assign set_ev[0] = run_reg && !free && ((dly_reg[0] == `PSS_DLY_ONE)
                     || (adv_src_reg == pss_pkg::SRC_LINE && line_rise)
                     || (adv_src_reg == pss_pkg::SRC_EVERY && frame_pulse_reg));
  assign set_ev[1] = run_reg && !free && ((dly_reg[1] == `PSS_DLY_ONE)
                     || (rst_src_reg == pss_pkg::SRC_LINE && line_rise));

  for (genvar g = 0; g < 2; g++) begin : g_cmd
    // Command delay counter
    always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
        dly_reg[g] <= `PSS_DLY_ZERO;
      end else if (cmd_ok[g] && run_reg) begin
        dly_reg[g] <= `PSS_DLY_W'(`PSS_ASYNC_DELAY_CYC);
      end else if (dly_reg[g] != `PSS_DLY_ZERO) begin
        dly_reg[g] <= dly_reg[g] - `PSS_DLY_ONE;
      end
    end
    // Pending flag, a new event wins over its clear
    always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
        pend_reg[g] <= 1'b0;
      end else if (set_ev[g]) begin
        pend_reg[g] <= 1'b1;
      end else if (clr[g] || !run_reg) begin
        pend_reg[g] <= 1'b0;
      end
    end
  end

  // Outputs
  assign ACTIVE_PARAM_O        = active_reg;
  assign WAITING_FOR_TRIGGER_O = waiting_reg;
  assign FRAME_START_O         = frame_pulse_reg;
  assign CURRENT_SET_O         = cur_reg;
  assign SEQ_RUNNING_O         = run_reg;

  // Checks
  property p_cap_ctrl;
    @(posedge CORE_CLK_I) disable iff (RST_I) !free |-> cnt_lim <= 7'h40;
  endproperty
  a_cap_ctrl: assert property (p_cap_ctrl) else $error("count above 64");
  property p_cap_free;
    @(posedge CORE_CLK_I) disable iff (RST_I) free |-> last_idx <= 6'h01;
  endproperty
  a_cap_free: assert property (p_cap_free) else $error("free count above 2");
  property p_start;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      $rose(SEQUENCER_ON_I) && !free && state_reg == pss_pkg::ST_WAIT |=> ##1 state_reg == pss_pkg::ST_FETCH
      && ld_idx_reg == 6'h00 ##2 cur_reg == 6'h00;
  endproperty
  a_start: assert property (p_start) else $error("enable did not load set 0");
  property p_load;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      state_reg == pss_pkg::ST_APPLY |=> active_reg == ($past(valid_reg[ld_idx_reg]) ? $past(u_mif.rdata) : 16'h0000);
  endproperty
  a_load: assert property (p_load) else $error("active set not loaded");
  property p_pick;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      state_reg == pss_pkg::ST_WAIT && trig_ok && free && run_reg && SEQUENCER_ON_I && (fresh_reg
      || sel_addr != cur_reg) |=> state_reg == pss_pkg::ST_FETCH && ld_idx_reg[0] == $past(line_reg ^ LINE_INVERT_I);
  endproperty
  a_pick: assert property (p_pick) else $error("wrong set picked from line");
  property p_keep;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      state_reg == pss_pkg::ST_WAIT && trig_ok && free && run_reg && SEQUENCER_ON_I && !fresh_reg
      && sel_addr == cur_reg |=> frame_pulse_reg && $stable(cur_reg) && state_reg == pss_pkg::ST_FRAME;
  endproperty
  a_keep: assert property (p_keep) else $error("unchanged line reloaded");
  property p_settle;
    @(posedge CORE_CLK_I) disable iff (RST_I) line_chg && free && run_reg |=> !waiting_reg [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("waiting during line change");
  property p_restore;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      restore_go |=> active_reg == $past(saved_reg) && !run_reg;
  endproperty
  a_restore: assert property (p_restore) else $error("parameters not restored");
  property p_rewind;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      UNSYNCED_REWIND_CMD_I && run_reg && !free && !SOURCE_WRITE_I |-> ##125 (pend_reg[1] || !run_reg
      || state_reg != pss_pkg::ST_WAIT || dly_reg[1] != 8'h00);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind not pending after delay");
  property p_src;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      SOURCE_WRITE_I && SOURCE_TARGET_SELECT_I && SOURCE_CHOICE_I == 2'h0 |=> rst_src_reg == pss_pkg::SRC_OFF;
  endproperty
  a_src: assert property (p_src) else $error("restart took every trigger");
endmodule

`default_nettype wire

/* File: pkg/pss_consts.svh */
// Constants for the parameter set sequencer
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_PARAM_W        16
`define PSS_IDX_W          6
`define PSS_CNT_W          7
`define PSS_DLY_W          8
`define PSS_MAX_SETS_CTRL  7'h40
`define PSS_MAX_SETS_FREE  7'h02
`define PSS_CNT_ZERO       7'h00
`define PSS_CNT_ONE        7'h01
`define PSS_IDX_ZERO       6'h00
`define PSS_IDX_ONE        6'h01
`define PSS_DEFAULT_PARAM  16'h0000
`define PSS_RESET_PARAM    16'h0000
`define PSS_SRC_EVERY      2'h0
`define PSS_SRC_LINE       2'h1
`define PSS_STYLE_FREE     1'b1
`define PSS_TGT_ADVANCE    1'b0
`define PSS_CLK_MHZ        125
`define PSS_ASYNC_DELAY_NS 1000
`define PSS_SETTLE_NS      80
`define PSS_ASYNC_DELAY_CYC ((`PSS_ASYNC_DELAY_NS * `PSS_CLK_MHZ) / 1000)
`define PSS_SETTLE_CYC     ((`PSS_SETTLE_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_DLY_ZERO       8'h00
`define PSS_DLY_ONE        8'h01

`endif

/* File: pkg/pss_pkg.sv */
// Types for the parameter set sequencer
`default_nettype none

package pss_pkg;
  typedef enum logic [1:0] {ST_WAIT, ST_FETCH, ST_APPLY, ST_FRAME} pss_state_t;
  typedef enum logic [1:0] {SRC_EVERY, SRC_LINE, SRC_OFF} pss_src_t;
endpackage

`default_nettype wire

/* File: pkg/pss_mem_if.sv */
// Carrier between the sequencer and its set memory
`default_nettype none
`include "pss_consts.svh"

interface pss_mem_if;
  logic                    we;
  logic                    re;
  logic [`PSS_IDX_W-1:0]   waddr;
  logic [`PSS_IDX_W-1:0]   raddr;
  logic [`PSS_PARAM_W-1:0] wdata;
  logic [`PSS_PARAM_W-1:0] rdata;
  modport ctrl (output we, re, waddr, raddr, wdata, input rdata);
  modport mem  (input we, re, waddr, raddr, wdata, output rdata);
endinterface

`default_nettype wire

/* File: src/pss_set_mem.sv */
// Stored parameter sets with registered read data
`default_nettype none
`include "pss_consts.svh"

module pss_set_mem (
  // Clock
  input wire logic clk_i,
  // Memory access
  pss_mem_if.mem   m
);
  logic [`PSS_PARAM_W-1:0] slots [64];

  // Write port
  always_ff @(posedge clk_i) begin
    if (m.we) begin
      slots[m.waddr] <= m.wdata;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (m.re) begin
      m.rdata <= slots[m.raddr];
    end
  end
endmodule

`default_nettype wire

/* File: tb/pss_trigger_model.sv */
// Frame trigger source and selection line driver facing the sequencer
`default_nettype none

module pss_trigger_model (
  // Clock and status
  input  wire logic clk_i,
  input  wire logic waiting_i,
  // Requests from the bench
  input  wire logic fire_i,
  input  wire logic line_lvl_i,
  // Pins
  output logic      trig_o,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int hold_cnt;

  // Line is a driven pin, so it simply follows the requested level
  assign line_o = line_lvl_i;

  // Trigger pulse is long enough to pass the three flop sync, raised only while waiting
  initial begin
    trig_o   = 1'b0;
    hold_cnt = 0;
    forever begin
      @(posedge clk_i);
      #1;
      if (hold_cnt > 0) begin
        hold_cnt = hold_cnt - 1;
        trig_o   = (hold_cnt > 0);
      end else if (fire_i && waiting_i) begin
        trig_o   = 1'b1;
        hold_cnt = 6;
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the parameter set sequencer
`default_nettype none
`include "pss_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk, rst, on, style, inv, tgt, swr, save, copy, step, rew, awr, done;
  logic                    fire, line_lvl, trig, line, waiting, fstart, running;
  logic [1:0]              src_ch;
  logic [`PSS_CNT_W-1:0]   cnt;
  logic [`PSS_IDX_W-1:0]   ptr, cur;
  logic [`PSS_PARAM_W-1:0] awdata, act;
  int                      num_errors, compares;

  // Device under test
  pss_sequencer pss_sequencer_inst (
    .CORE_CLK_I(clk), .RST_I(rst), .SEQUENCER_ON_I(on), .SET_STEPPING_STYLE_I(style),
    .SET_COUNT_I(cnt), .LINE_INVERT_I(inv), .SOURCE_TARGET_SELECT_I(tgt), .SOURCE_CHOICE_I(src_ch),
    .SOURCE_WRITE_I(swr), .SET_POINTER_I(ptr), .SAVE_ACTIVE_TO_SLOT_I(save), .COPY_SLOT_TO_ACTIVE_I(copy),
    .UNSYNCED_STEP_CMD_I(step), .UNSYNCED_REWIND_CMD_I(rew), .ACTIVE_WR_I(awr), .ACTIVE_WDATA_I(awdata),
    .INPUT_LINE_ONE_I(line), .FRAME_TRIGGER_I(trig), .FRAME_DONE_I(done), .ACTIVE_PARAM_O(act),
    .WAITING_FOR_TRIGGER_O(waiting), .FRAME_START_O(fstart), .CURRENT_SET_O(cur), .SEQ_RUNNING_O(running)
  );

  // Far side: trigger source and selection line
  pss_trigger_model pss_trigger_model_inst (
    .clk_i(clk), .waiting_i(waiting), .fire_i(fire), .line_lvl_i(line_lvl), .trig_o(trig), .line_o(line)
  );

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s ended, mismatches so far %0d", name, num_errors);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cfg_src(input logic t, input logic [1:0] ch);
    tgt    = t;
    src_ch = ch;
    swr    = 1'b1;
    tick();
    swr    = 1'b0;
    tick();
  endtask

  task automatic wr_act(input logic [15:0] v);
    awdata = v;
    awr    = 1'b1;
    tick();
    awr    = 1'b0;
    tick();
  endtask

  task automatic store(input logic [5:0] idx, input logic [15:0] v);
    wr_act(v);
    ptr  = idx;
    save = 1'b1;
    tick();
    save = 1'b0;
    tick();
  endtask

  task automatic load(input logic [5:0] idx, input logic [15:0] v);
    ptr  = idx;
    copy = 1'b1;
    tick();
    copy = 1'b0;
    tick(5);
    chk(act, v);
  endtask

  task automatic wait_load(input logic [5:0] idx, input logic [15:0] v);
    for (int i = 0; i < 400 && !(cur === idx && act === v); i++) tick();
    chk(act, v);
    chk({10'h000, cur}, {10'h000, idx});
  endtask

  task automatic unsynced(input logic is_rew);
    rew  = is_rew;
    step = ~is_rew;
    tick();
    rew  = 1'b0;
    step = 1'b0;
  endtask

  task automatic frame(input logic [5:0] idx, input logic [15:0] v, input logic off_mid);
    fire = 1'b1;
    for (int i = 0; i < 80 && fstart !== 1'b1; i++) tick();
    fire = 1'b0;
    chk({15'h0000, fstart}, 16'h0001);
    chk(act, v);
    chk({10'h000, cur}, {10'h000, idx});
    if (off_mid) on = 1'b0;
    tick(5);
    chk(act, v);
    done = 1'b1;
    tick();
    done = 1'b0;
    tick(2);
  endtask

  task automatic wait_off;
    on = 1'b0;
    for (int i = 0; i < 80 && running !== 1'b0; i++) tick();
    tick(2);
    chk(act, 16'hD0D0);
    chk({15'h0000, running}, 16'h0000);
  endtask

  // Hang guard
  initial begin
    #400us;
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    {rst, on, style, inv, tgt, swr, save, copy, step, rew, awr, done, fire, line_lvl} = 14'h0000;
    src_ch = 2'h2;
    cnt    = 7'h03;
    ptr    = 6'h00;
    awdata = 16'h0000;
    rst    = 1'b1;
    tick(6);
    rst    = 1'b0;
    tick(2);
    chk(act, 16'h0000);
    chk({10'h000, cur}, 16'h0000);
    chk({15'h0000, running}, 16'h0000);
    end_test("reset");
    store(6'h00, 16'h1111);
    store(6'h00, 16'hA0A0);
    store(6'h01, 16'hB1B1);
    store(6'h02, 16'hC2C2);
    store(6'h3F, 16'hEEEE);
    load(6'h3F, 16'hEEEE);
    load(6'h01, 16'hB1B1);
    load(6'h05, 16'h0000);
    wr_act(16'hD0D0);
    end_test("store_copy");
    cfg_src(`PSS_TGT_ADVANCE, 2'h2);
    cfg_src(~`PSS_TGT_ADVANCE, 2'h2);
    on = 1'b1;
    wait_load(6'h00, 16'hA0A0);
    unsynced(1'b0);
    tick(50);
    chk({10'h000, cur}, 16'h0000);
    wait_load(6'h01, 16'hB1B1);
    unsynced(1'b0);
    wait_load(6'h02, 16'hC2C2);
    unsynced(1'b0);
    wait_load(6'h00, 16'hA0A0);
    unsynced(1'b0);
    wait_load(6'h01, 16'hB1B1);
    unsynced(1'b1);
    wait_load(6'h00, 16'hA0A0);
    wait_off();
    end_test("unsynced");
    cnt = 7'h02;
    cfg_src(`PSS_TGT_ADVANCE, `PSS_SRC_EVERY);
    on = 1'b1;
    wait_load(6'h00, 16'hA0A0);
    frame(6'h00, 16'hA0A0, 1'b0);
    wait_load(6'h01, 16'hB1B1);
    frame(6'h01, 16'hB1B1, 1'b0);
    wait_load(6'h00, 16'hA0A0);
    wait_off();
    cfg_src(`PSS_TGT_ADVANCE, `PSS_SRC_LINE);
    on = 1'b1;
    wait_load(6'h00, 16'hA0A0);
    line_lvl = 1'b1;
    wait_load(6'h01, 16'hB1B1);
    line_lvl = 1'b0;
    wait_off();
    // Restart from the line while advance runs on unsynced steps only
    cfg_src(`PSS_TGT_ADVANCE, 2'h2);
    cfg_src(~`PSS_TGT_ADVANCE, `PSS_SRC_LINE);
    on = 1'b1;
    wait_load(6'h00, 16'hA0A0);
    unsynced(1'b0);
    wait_load(6'h01, 16'hB1B1);
    line_lvl = 1'b1;
    wait_load(6'h00, 16'hA0A0);
    line_lvl = 1'b0;
    wait_off();
    // Every trigger is no restart choice, so restart falls back to disabled
    cfg_src(~`PSS_TGT_ADVANCE, `PSS_SRC_EVERY);
    end_test("controlled");
    style = `PSS_STYLE_FREE;
    on    = 1'b1;
    tick(3);
    frame(6'h00, 16'hA0A0, 1'b0);
    line_lvl = 1'b1;
    for (int i = 0; i < 20 && waiting !== 1'b0; i++) tick();
    chk({15'h0000, waiting}, 16'h0000);
    frame(6'h01, 16'hB1B1, 1'b0);
    frame(6'h01, 16'hB1B1, 1'b0);
    inv = 1'b1;
    tick(20);
    frame(6'h00, 16'hA0A0, 1'b0);
    line_lvl = 1'b0;
    tick(20);
    frame(6'h01, 16'hB1B1, 1'b1);
    wait_off();
    end_test("pick");
    finish_test();
  end
endmodule

`default_nettype wire
